// ==== sib_consts.svh ====
// register offsets, field positions, reset values and cycle numbers
`ifndef SIB_CONSTS_SVH
`define SIB_CONSTS_SVH

// register byte offsets on the apb bus
`define SIB_OFF_CTRL 8'h00
`define SIB_OFF_EOI 8'h04
`define SIB_OFF_MSG 8'h08
`define SIB_OFF_STAT 8'h0C
`define SIB_OFF_RX 8'h10

// control register fields and reset value
`define SIB_CTRL_RST 18'h00000
`define SIB_CTRL_ARB_LSB 0
`define SIB_CTRL_PHYS_LSB 4
`define SIB_CTRL_LOG_LSB 8
`define SIB_CTRL_FOCUS_BIT 16
`define SIB_CTRL_EN_BIT 17

// message launch register fields
`define SIB_MSG_VEC_LSB 0
`define SIB_MSG_DEST_LSB 8
`define SIB_MSG_DM_BIT 16
`define SIB_MSG_KIND_LSB 17
`define SIB_MSG_LVL_BIT 20
`define SIB_MSG_TRIG_BIT 21
`define SIB_MSG_SH_LSB 22

// status register bits
`define SIB_STAT_BUSY 0
`define SIB_STAT_DONE 1
`define SIB_STAT_TXERR 2
`define SIB_STAT_RXV 3
`define SIB_STAT_CKSE 4

// message type codes driven in cycle 1
`define SIB_TYPE_EOI 2'h3
`define SIB_TYPE_SHORT 2'h1

// message lengths in bus cycles
`define SIB_LEN_EOI 6'h0E
`define SIB_LEN_SHORT 6'h15
`define SIB_LEN_LOWEST 6'h22

// cycle numbers within a message
`define SIB_CYC_TYPE 6'h01
`define SIB_CYC_ARB_FIRST 6'h02
`define SIB_CYC_ARB_LAST 6'h05
`define SIB_CYC_BODY 6'h06
`define SIB_CYC_E_LAST 6'h09
`define SIB_CYC_E_CKS 6'h0A
`define SIB_CYC_E_ST0 6'h0C
`define SIB_CYC_E_ST1 6'h0D
`define SIB_CYC_S_VEC 6'h09
`define SIB_CYC_S_DEST 6'h0D
`define SIB_CYC_S_LAST 6'h10
`define SIB_CYC_S_CKS 6'h11
`define SIB_CYC_S_ST0 6'h13
`define SIB_CYC_S_ST1 6'h14
`define SIB_CYC_L_A2 6'h21

// status pair codes
`define SIB_ST_OK 2'h0
`define SIB_ST_CKS_ERR 2'h3
`define SIB_ST_ACCEPT 2'h2
`define SIB_ST_RETRY 2'h3
`define SIB_ST_FOCUS 2'h2

// delivery kinds, shorthands, broadcast identifier
`define SIB_KIND_LOWEST 3'h1
`define SIB_SH_INCL 2'h1
`define SIB_SH_EXCL 2'h2
`define SIB_ARB_BCAST 4'hF

`endif

// ==== sib_pkg.sv ====
// types shared by the serial interrupt bus framer
package sib_pkg;
  // node role on the bus, one-hot
  typedef enum logic [2:0] {
    SIB_ROLE_IDLE = 3'b001,
    SIB_ROLE_SEND = 3'b010,
    SIB_ROLE_RECV = 3'b100
  } sib_role_type;
  // decoded register selector
  typedef enum logic [2:0] {
    SIB_REG_CTRL, SIB_REG_EOI, SIB_REG_MSG, SIB_REG_STAT, SIB_REG_RX,
    SIB_REG_NONE
  } sib_reg_type;
endpackage

// ==== sib_sync.sv ====
// two-flop synchroniser for asynchronous pin inputs
module sib_sync #(
  parameter int WIDTH = 3
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // raw and synchronised levels
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta_r; // first stage, read only by q

  // one independent chain per bit
  for (genvar i = 0; i < WIDTH; i++) begin : g_bit
    always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
        meta_r[i] <= 1'b0;
        q[i] <= 1'b0;
      end else begin
        meta_r[i] <= d[i];
        q[i] <= meta_r[i];
      end
    end
  end
endmodule

// ==== sib_csum.sv ====
// running two-bit checksum with end-around carry
module sib_csum (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // control
  input wire logic clear,
  input wire logic add,
  input wire logic last,
  // data
  input wire logic [1:0] val,
  output logic [1:0] sum
);
  logic [2:0] raw; // plain sum with carry

  assign raw = {1'b0, sum} + {1'b0, val};

  // the final addition drops its carry, all others fold it back in
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      sum <= 2'h0;
    end else if (clear) begin
      sum <= 2'h0;
    end else if (add) begin
      if (last) begin
        sum <= raw[1:0];
      end else begin
        sum <= raw[1:0] + {1'b0, raw[2]};
      end
    end
  end
endmodule

// ==== sib_framer.sv ====
// serial interrupt bus framer node with apb register access
//
// How it works
// - node handles notice, short and lowest messages
// - local node sends 14-cycle end-of-interrupt notice
// - notice starts on end-of-interrupt register write
// - notice layout: type 11, vector, checksum, status
// - cycles 2-5 carry identifier on high lane
// - checksum folds carry back except final add
// - checksum mismatch drives 11 in error status
// - sender sees error and resends same message
// - short message carries all non-notice deliveries
// - short layout: type 01, vector, destination, status
// - cycles 6-8 carry mode, kind, level, trigger
// - short checksum in cycle 17 over 6-16
// - physical uses low destination, logical uses all
// - shorthands use physical mode and identifier 1111
// - focus node drives 10 in cycle 19
// - unclaimed lowest message extends without gap
// - errored non-notice messages end after cycle 21
// - status pairs decode ok, error, accept, retry
// - good lowest status 00 runs full 34 cycles
`include "sib_consts.svh"
module sib_framer import sib_pkg::*; (
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // serial bus clock pin
  input wire logic bus_clk_in,
  // high lane (bit1), open drain
  input wire logic lane_hi_in,
  output logic lane_hi_out,
  output logic lane_hi_oe_n,
  // low lane (bit0), open drain
  input wire logic lane_lo_in,
  output logic lane_lo_out,
  output logic lane_lo_oe_n
);
  // synchronised pins and bus clock edges
  logic [2:0] sync_w;      // {bus clock, high lane, low lane}
  logic bclk_d_r;          // previous bus clock level
  logic rise;              // bus sampling edge
  logic fall;              // bus drive edge
  logic [1:0] lanes;       // current pair on the bus
  // message tracking
  logic [5:0] cyc_r;       // cycle of the last sample, 0 when idle
  logic [5:0] ncyc;        // cycle being driven or sampled next
  logic [5:0] msg_len;     // length of the message in flight
  logic [1:0] mtype_r;     // type code seen in cycle 1
  logic is_eoi;            // message is an end-of-interrupt notice
  logic ext_r;             // message extended to lowest form
  sib_role_type role_r;    // our part in the current message
  // received fields
  logic [7:0] cap_vec_r;
  logic [7:0] cap_dest_r;
  logic cap_dm_r;
  logic [2:0] cap_kind_r;
  logic cap_lvl_r;
  logic cap_trig_r;
  logic cks_bad_r;         // our checksum disagreed with the bus
  logic claim_r;           // we claimed as focus node
  logic [1:0] cks_sum;     // running checksum of the bus
  logic [1:0] arb_i;       // pair index for cycles 2-5 and 6-9
  logic [1:0] sh_i;        // pair index for cycles 9-16
  logic covered;           // cycle is inside the checksum
  logic cov_last;          // last cycle inside the checksum
  logic addr_hit;          // short message is addressed to us
  logic is_lowest;
  // transmit side
  logic pend_r;            // a message waits to be sent
  logic tx_eoi_r;
  logic [3:0] tx_arb_r;
  logic [7:0] tx_vec_r;
  logic [7:0] tx_dest_r;
  logic tx_dm_r;
  logic [2:0] tx_kind_r;
  logic tx_lvl_r;
  logic tx_trig_r;
  logic tx_incl_r;         // shorthand that includes ourselves
  logic tx_ok_r;           // no bad status seen this attempt
  logic [1:0] tx_pair;     // our data for cycle ncyc
  logic [1:0] drv_nxt;     // total pair we pull for cycle ncyc
  logic [1:0] drv_r;       // pair we pull in the current cycle
  logic starting;          // we open a message at this drive edge
  // registers
  logic [17:0] ctrl_r;
  logic done_r, txerr_r, rxv_r, ckse_r;
  logic [13:0] rx_r;       // latched accepted message
  logic acc;               // apb access completes this edge
  logic wr;                // write completes this edge
  logic launch_ok;         // launch register may be written
  sib_reg_type sel;

  // decode an apb address to a register
  function automatic sib_reg_type reg_sel(input logic [7:0] a);
    case (a)
      `SIB_OFF_CTRL: reg_sel = SIB_REG_CTRL;
      `SIB_OFF_EOI: reg_sel = SIB_REG_EOI;
      `SIB_OFF_MSG: reg_sel = SIB_REG_MSG;
      `SIB_OFF_STAT: reg_sel = SIB_REG_STAT;
      `SIB_OFF_RX: reg_sel = SIB_REG_RX;
      default: reg_sel = SIB_REG_NONE;
    endcase
  endfunction

  // pick pair i of a byte, most significant pair first
  function automatic logic [1:0] pair_of(input logic [7:0] b,
                                         input logic [1:0] i);
    pair_of = b[{~i, 1'b1} -: 2];
  endfunction

  sib_sync #(.WIDTH(3)) u_sync (
    .clk(ref_clk),
    .reset(reset),
    .d({bus_clk_in, lane_hi_in, lane_lo_in}),
    .q(sync_w)
  );

  // bus clock edge detect, on the synchronised level only
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      bclk_d_r <= 1'b0;
    end else begin
      bclk_d_r <= sync_w[2];
    end
  end

  assign rise = sync_w[2] & ~bclk_d_r;
  assign fall = ~sync_w[2] & bclk_d_r;
  assign lanes = sync_w[1:0];
  assign ncyc = (cyc_r == 6'h00) ? `SIB_CYC_TYPE : cyc_r + 6'h01;
  assign is_eoi = (mtype_r == `SIB_TYPE_EOI);
  assign is_lowest = (cap_kind_r == `SIB_KIND_LOWEST);
  assign arb_i = ncyc[1:0] + 2'h2;
  assign sh_i = ncyc[1:0] + 2'h3;
  // three kinds only: notice, short, and short extended to lowest
  assign msg_len = is_eoi ? `SIB_LEN_EOI :
                   (ext_r ? `SIB_LEN_LOWEST : `SIB_LEN_SHORT);
  assign covered = (ncyc >= `SIB_CYC_BODY) &&
                   (ncyc <= (is_eoi ? `SIB_CYC_E_LAST : `SIB_CYC_S_LAST));
  assign cov_last = (ncyc == (is_eoi ? `SIB_CYC_E_LAST : `SIB_CYC_S_LAST));

  // physical mode matches only the low four destination bits
  always_comb begin
    if (!cap_dm_r) begin
      addr_hit = (cap_dest_r[3:0] == ctrl_r[`SIB_CTRL_PHYS_LSB +: 4]) ||
                 (cap_dest_r[3:0] == `SIB_ARB_BCAST);
    end else begin
      addr_hit = |(cap_dest_r & ctrl_r[`SIB_CTRL_LOG_LSB +: 8]);
    end
  end

  // checksum is taken from the bus, so the sender reuses it too
  sib_csum u_csum (
    .clk(ref_clk),
    .reset(reset),
    .clear(rise && (ncyc == `SIB_CYC_TYPE)),
    .add(rise && covered),
    .last(cov_last),
    .val(lanes),
    .sum(cks_sum)
  );

  // message cycle counter and type capture
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      cyc_r <= 6'h00;
      mtype_r <= 2'h0;
    end else if (rise) begin
      if (cyc_r == 6'h00) begin
        if (lanes != 2'h0) begin
          cyc_r <= `SIB_CYC_TYPE;
          mtype_r <= lanes;
        end
      end else if (ncyc == msg_len) begin
        cyc_r <= 6'h00;
      end else begin
        cyc_r <= ncyc;
      end
    end
  end

  // field capture, checksum compare and length decision
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      cap_vec_r <= 8'h00;
      cap_dest_r <= 8'h00;
      cap_dm_r <= 1'b0;
      cap_kind_r <= 3'h0;
      cap_lvl_r <= 1'b0;
      cap_trig_r <= 1'b0;
      cks_bad_r <= 1'b0;
      ext_r <= 1'b0;
    end else if (rise && (cyc_r != 6'h00 || lanes != 2'h0)) begin
      if (ncyc == `SIB_CYC_TYPE) begin
        cks_bad_r <= 1'b0;
        ext_r <= 1'b0;
      end else if (mtype_r == `SIB_TYPE_EOI) begin
        if (covered) begin
          cap_vec_r[{~arb_i, 1'b1} -: 2] <= lanes;
        end
        if (ncyc == `SIB_CYC_E_CKS && lanes != cks_sum) begin
          cks_bad_r <= 1'b1;
        end
      end else begin
        case (ncyc)
          6'h06: {cap_dm_r, cap_kind_r[2]} <= lanes;
          6'h07: cap_kind_r[1:0] <= lanes;
          6'h08: {cap_lvl_r, cap_trig_r} <= lanes;
          `SIB_CYC_S_CKS: cks_bad_r <= (lanes != cks_sum);
          // a clean status 00 on a lowest message extends it
          `SIB_CYC_S_ST0: ext_r <= is_lowest &&
                                   (lanes == `SIB_ST_OK);
          // acceptance error keeps the 21-cycle length
          `SIB_CYC_S_ST1: if (!lanes[1]) ext_r <= 1'b0;
          default: begin
            if (ncyc >= `SIB_CYC_S_VEC && ncyc < `SIB_CYC_S_DEST) begin
              cap_vec_r[{~sh_i, 1'b1} -: 2] <= lanes;
            end else if (ncyc >= `SIB_CYC_S_DEST &&
                         ncyc <= `SIB_CYC_S_LAST) begin
              cap_dest_r[{~sh_i, 1'b1} -: 2] <= lanes;
            end
          end
        endcase
      end
    end
  end

  // our own data for the upcoming cycle
  always_comb begin
    tx_pair = 2'h0;
    if (ncyc == `SIB_CYC_TYPE) begin
      tx_pair = tx_eoi_r ? `SIB_TYPE_EOI : `SIB_TYPE_SHORT;
    end else if (ncyc <= `SIB_CYC_ARB_LAST) begin
      tx_pair = {tx_arb_r[2'h3 - arb_i], 1'b0};
    end else if (tx_eoi_r) begin
      if (covered) begin
        tx_pair = pair_of(tx_vec_r, arb_i);
      end else if (ncyc == `SIB_CYC_E_CKS) begin
        tx_pair = cks_sum;
      end
    end else begin
      case (ncyc)
        6'h06: tx_pair = {tx_dm_r, tx_kind_r[2]};
        6'h07: tx_pair = tx_kind_r[1:0];
        6'h08: tx_pair = {tx_lvl_r, tx_trig_r};
        `SIB_CYC_S_CKS: tx_pair = cks_sum;
        default: begin
          if (ncyc >= `SIB_CYC_S_VEC && ncyc < `SIB_CYC_S_DEST) begin
            tx_pair = pair_of(tx_vec_r, sh_i);
          end else if (ncyc >= `SIB_CYC_S_DEST &&
                       ncyc <= `SIB_CYC_S_LAST) begin
            tx_pair = pair_of(tx_dest_r, sh_i);
          end
        end
      endcase
    end
  end

  assign starting = (cyc_r == 6'h00) && pend_r && (role_r == SIB_ROLE_IDLE)
                    && ctrl_r[`SIB_CTRL_EN_BIT];

  // everything we pull: sender data plus receiver status answers
  always_comb begin
    drv_nxt = 2'h0;
    if (starting || role_r == SIB_ROLE_SEND) begin
      drv_nxt = tx_pair;
    end else if (role_r == SIB_ROLE_RECV && ctrl_r[`SIB_CTRL_EN_BIT]) begin
      if (is_eoi) begin
        if (ncyc == `SIB_CYC_E_ST0 && cks_bad_r) begin
          drv_nxt = `SIB_ST_CKS_ERR;
        end
      end else if (ncyc == `SIB_CYC_S_ST0) begin
        if (cks_bad_r) begin
          drv_nxt = `SIB_ST_CKS_ERR;
        end else if (is_lowest && addr_hit &&
                     ctrl_r[`SIB_CTRL_FOCUS_BIT]) begin
          drv_nxt = `SIB_ST_FOCUS;
        end
      end else if (ncyc == `SIB_CYC_S_ST1 && !cks_bad_r &&
                   (claim_r || (!is_lowest && addr_hit))) begin
        // a full receive slot asks the sender to retry
        drv_nxt = rxv_r ? `SIB_ST_RETRY : `SIB_ST_ACCEPT;
      end
    end
  end

  // lane drivers change only on the bus clock falling edge
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      drv_r <= 2'h0;
      lane_hi_out <= 1'b0;
      lane_lo_out <= 1'b0;
      lane_hi_oe_n <= 1'b1;
      lane_lo_oe_n <= 1'b1;
    end else if (fall) begin
      drv_r <= drv_nxt;
      lane_hi_out <= drv_nxt[1];
      lane_lo_out <= drv_nxt[0];
      lane_hi_oe_n <= ~drv_nxt[1];
      lane_lo_oe_n <= ~drv_nxt[0];
    end
  end

  // role, arbitration loss and sender outcome
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      role_r <= SIB_ROLE_IDLE;
      tx_ok_r <= 1'b0;
      claim_r <= 1'b0;
    end else if (fall && starting) begin
      role_r <= SIB_ROLE_SEND;
      tx_ok_r <= 1'b1;
      claim_r <= 1'b0;
    end else if (rise) begin
      if (cyc_r != 6'h00 && ncyc == msg_len) begin
        role_r <= SIB_ROLE_IDLE;
      end else if (role_r == SIB_ROLE_IDLE && lanes != 2'h0) begin
        role_r <= SIB_ROLE_RECV;
        claim_r <= 1'b0;
      end else if (role_r == SIB_ROLE_SEND) begin
        // a one seen where we drove zero means a higher node won
        if (ncyc <= `SIB_CYC_ARB_LAST && lanes != drv_r) begin
          role_r <= SIB_ROLE_RECV;
        end
        if ((is_eoi && ncyc == `SIB_CYC_E_ST0 && lanes != `SIB_ST_OK) ||
            (is_eoi && ncyc == `SIB_CYC_E_ST1 &&
             lanes != `SIB_ST_ACCEPT)) begin
          tx_ok_r <= 1'b0;
        end
        if (!is_eoi && ncyc == `SIB_CYC_S_ST0 && lanes != `SIB_ST_OK &&
            !(is_lowest && lanes == `SIB_ST_FOCUS)) begin
          tx_ok_r <= 1'b0;
        end
        if (!is_eoi && ncyc == `SIB_CYC_S_ST1 &&
            (ext_r ? !lanes[1] : lanes != `SIB_ST_ACCEPT)) begin
          tx_ok_r <= 1'b0;
        end
        if (ncyc == `SIB_CYC_L_A2 && ext_r && lanes != `SIB_ST_ACCEPT) begin
          tx_ok_r <= 1'b0;
        end
      end else if (ncyc == `SIB_CYC_S_ST0 && drv_r == `SIB_ST_FOCUS &&
                   !is_eoi) begin
        claim_r <= 1'b1;
      end
    end
  end

  // apb handshake: one wait state, then pready for a single cycle
  assign acc = psel && penable && pready;
  assign wr = acc && pwrite;
  assign sel = reg_sel(paddr);
  assign launch_ok = !pend_r;

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= psel && penable && !pready;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
      if (psel && penable && !pready) begin
        // unmapped addresses and launches while busy are refused
        pslverr <= (sel == SIB_REG_NONE) || (pwrite && !launch_ok &&
                   (sel == SIB_REG_EOI || sel == SIB_REG_MSG));
        if (!pwrite) begin
          case (sel)
            SIB_REG_CTRL: prdata <= {14'h0000, ctrl_r};
            SIB_REG_STAT: prdata <= {27'h0000000, ckse_r, rxv_r, txerr_r,
                                     done_r, pend_r};
            SIB_REG_RX: prdata <= {18'h00000, rx_r};
            default: prdata <= 32'h0000_0000;
          endcase
        end
      end
    end
  end

  // control register
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      ctrl_r <= `SIB_CTRL_RST;
    end else if (wr && sel == SIB_REG_CTRL) begin
      ctrl_r <= pwdata[17:0];
    end
  end

  // launch registers: notice or short message, one at a time
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      pend_r <= 1'b0;
      tx_eoi_r <= 1'b0;
      tx_arb_r <= 4'h0;
      tx_vec_r <= 8'h00;
      tx_dest_r <= 8'h00;
      tx_dm_r <= 1'b0;
      tx_kind_r <= 3'h0;
      tx_lvl_r <= 1'b0;
      tx_trig_r <= 1'b0;
      tx_incl_r <= 1'b0;
    end else if (wr && launch_ok && sel == SIB_REG_EOI) begin
      pend_r <= 1'b1;
      tx_eoi_r <= 1'b1;
      tx_arb_r <= ctrl_r[`SIB_CTRL_ARB_LSB +: 4];
      tx_vec_r <= pwdata[7:0];
    end else if (wr && launch_ok && sel == SIB_REG_MSG) begin
      pend_r <= 1'b1;
      tx_eoi_r <= 1'b0;
      tx_vec_r <= pwdata[`SIB_MSG_VEC_LSB +: 8];
      tx_kind_r <= pwdata[`SIB_MSG_KIND_LSB +: 3];
      tx_lvl_r <= pwdata[`SIB_MSG_LVL_BIT];
      tx_trig_r <= pwdata[`SIB_MSG_TRIG_BIT];
      tx_incl_r <= (pwdata[`SIB_MSG_SH_LSB +: 2] == `SIB_SH_INCL);
      if (pwdata[`SIB_MSG_SH_LSB +: 2] == `SIB_SH_INCL ||
          pwdata[`SIB_MSG_SH_LSB +: 2] == `SIB_SH_EXCL) begin
        tx_dm_r <= 1'b0;
        tx_dest_r <= {4'h0, `SIB_ARB_BCAST};
        tx_arb_r <= `SIB_ARB_BCAST;
      end else begin
        tx_dm_r <= pwdata[`SIB_MSG_DM_BIT];
        tx_dest_r <= pwdata[`SIB_MSG_DEST_LSB +: 8];
        tx_arb_r <= ctrl_r[`SIB_CTRL_ARB_LSB +: 4];
      end
    end else if (rise && role_r == SIB_ROLE_SEND && cyc_r != 6'h00 &&
                 ncyc == msg_len && tx_ok_r) begin
      pend_r <= 1'b0; // failed attempts keep pend_r and resend
    end
  end

  // sticky status flags: hardware set wins over write-one-to-clear
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      done_r <= 1'b0;
      txerr_r <= 1'b0;
      rxv_r <= 1'b0;
      ckse_r <= 1'b0;
      rx_r <= 14'h0000;
    end else begin
      if (wr && sel == SIB_REG_STAT) begin
        if (pwdata[`SIB_STAT_DONE]) done_r <= 1'b0;
        if (pwdata[`SIB_STAT_TXERR]) txerr_r <= 1'b0;
        if (pwdata[`SIB_STAT_RXV]) rxv_r <= 1'b0;
        if (pwdata[`SIB_STAT_CKSE]) ckse_r <= 1'b0;
      end
      if (rise && cyc_r != 6'h00 && ncyc == msg_len &&
          role_r == SIB_ROLE_SEND) begin
        if (tx_ok_r) done_r <= 1'b1;
        if (!tx_ok_r) txerr_r <= 1'b1;
        if (tx_ok_r && tx_incl_r) begin
          rxv_r <= 1'b1; // self copy of an all-incl shorthand
          rx_r <= {tx_trig_r, tx_lvl_r, tx_dm_r, tx_kind_r, tx_vec_r};
        end
      end
      if (rise && !is_eoi && ncyc == `SIB_CYC_S_ST1 &&
          drv_r == `SIB_ST_ACCEPT && role_r == SIB_ROLE_RECV) begin
        rxv_r <= 1'b1;
        rx_r <= {cap_trig_r, cap_lvl_r, cap_dm_r, cap_kind_r, cap_vec_r};
      end
      if (rise && cks_bad_r && cyc_r != 6'h00 && ncyc == msg_len) begin
        ckse_r <= 1'b1; // message discarded
      end
    end
  end
endmodule

// ==== sib_framer_sva.sv ====
// apb timing and lane drive checks for the framer node
module sib_framer_sva (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic bus_clk_in,
  input wire logic lane_hi_in,
  input wire logic lane_hi_out,
  input wire logic lane_hi_oe_n,
  input wire logic lane_lo_in,
  input wire logic lane_lo_out,
  input wire logic lane_lo_oe_n
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);
  // one wait state after the access phase starts
  property p_wait; psel && !penable |-> ##2 pready; endproperty
  a_wait: assert property (p_wait) else $error("ready late");
  // the answer stands a single cycle
  property p_pulse; pready |=> !pready; endproperty
  a_pulse: assert property (p_pulse) else $error("ready held");
  // no answer without an access phase
  property p_ans; pready |-> $past(psel && penable); endproperty
  a_ans: assert property (p_ans) else $error("stray ready");
  // read data is quiet between answers
  property p_zero; !pready |-> prdata == 32'h0; endproperty
  a_zero: assert property (p_zero) else $error("data leak");
  // addresses past the last register are refused
  property p_err; pready && paddr > 8'h10 |-> pslverr; endproperty
  a_err: assert property (p_err) else $error("no refusal");
  property p_errv; pslverr |-> pready; endproperty
  a_errv: assert property (p_errv) else $error("error alone");
  // a lane drive stands for at least seven clocks once it changes
  property p_stand;
    $changed({lane_hi_oe_n, lane_lo_oe_n}) |=>
      $stable({lane_hi_oe_n, lane_lo_oe_n}) [*6];
  endproperty
  a_stand: assert property (p_stand) else $error("short drive");
  // lanes stay released at the first edge after reset
  property p_rel;
    $fell(reset) |-> lane_hi_oe_n && lane_lo_oe_n && !pready;
  endproperty
  a_rel: assert property (p_rel) else $error("drive at reset");
  c_err: cover property (pready && pslverr);
  c_eoi: cover property ($fell(lane_hi_oe_n) && !lane_lo_oe_n);
  c_lo: cover property ($fell(lane_lo_oe_n));
endmodule
bind sib_framer sib_framer_sva i_sva (.ref_clk(ref_clk), .reset(reset),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .bus_clk_in(bus_clk_in), .lane_hi_in(lane_hi_in),
  .lane_hi_out(lane_hi_out), .lane_hi_oe_n(lane_hi_oe_n),
  .lane_lo_in(lane_lo_in), .lane_lo_out(lane_lo_out),
  .lane_lo_oe_n(lane_lo_oe_n));

// ==== sib_peer.sv ====
// bus clock source and a peer node on the wired lanes
module sib_peer (
  // bus clock and wired lanes
  output logic bclk,
  input wire logic hi,
  input wire logic lo,
  output logic p_hi,
  output logic p_lo,
  // number of the message to flag as a checksum error
  input wire logic [31:0] bad_at
);
  timeunit 1ns;
  timeprecision 1ns;
  int cyc = 0; // message cycle, 0 while idle
  int len = 21; // length of the current message
  int n_msg = 0; // messages seen so far
  logic [1:0] rec [1:21]; // pair sampled in each cycle
  // odd offset keeps bus edges off the system clock edges
  initial begin
    {bclk, p_hi, p_lo} = 3'h0;
    #7;
    forever #160 bclk = ~bclk;
  end
  // sample on rise; the type code fixes the length
  always @(posedge bclk) begin
    if (cyc == 0 && {hi, lo} != 2'h0) begin
      cyc = 1;
      len = ({hi, lo} == 2'h3) ? 14 : 21;
      n_msg++;
    end else if (cyc != 0) cyc++;
    if (cyc != 0) rec[cyc] = {hi, lo};
    if (cyc >= len) cyc = 0;
  end
  // status pairs are driven on the fall before their cycle
  always @(negedge bclk) begin
    {p_hi, p_lo} = 2'h0;
    if (cyc == len - 3 && n_msg == bad_at) begin
      {p_hi, p_lo} = 2'h3;
    end
    if (cyc == len - 2 && n_msg != bad_at) p_hi = 1'b1;
  end
endmodule

// ==== tb_top.sv ====
// self-checking bench for the framer node
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk = 0, reset = 1, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, r;
  logic pready, pslverr, bclk, hi_o, hi_n, lo_o, lo_n, p_hi, p_lo, e;
  logic hi_w, lo_w; // wired lanes, undriven reads 0
  int bad_at = 0, bad_count = 0, n_tests = 0, m0;
  // reads after reset: address, data, refusal
  logic [40:0] rows [7] = '{{8'h00, 32'h0, 1'b0}, {8'h04, 32'h0, 1'b0},
    {8'h08, 32'h0, 1'b0}, {8'h0C, 32'h0, 1'b0}, {8'h10, 32'h0, 1'b0},
    {8'h14, 32'h0, 1'b1}, {8'hFC, 32'h0, 1'b1}};
  assign hi_w = p_hi | (hi_o & ~hi_n);
  assign lo_w = p_lo | (lo_o & ~lo_n);
  always #20 ref_clk = ~ref_clk;
  sib_framer i_dut (.ref_clk(ref_clk), .reset(reset), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .bus_clk_in(bclk), .lane_hi_in(hi_w), .lane_hi_out(hi_o),
    .lane_hi_oe_n(hi_n), .lane_lo_in(lo_w), .lane_lo_out(lo_o),
    .lane_lo_oe_n(lo_n));
  sib_peer i_peer (.bclk(bclk), .hi(hi_w), .lo(lo_w), .p_hi(p_hi),
    .p_lo(p_lo), .bad_at(bad_at));
  task automatic chk(input string n, input logic [31:0] s, x);
    n_tests++;
    if (s !== x) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", n, x, s);
    end
  endtask
  // one apb transfer, held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a,
    input logic [31:0] d);
    @(posedge ref_clk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge ref_clk);
    penable <= 1'b1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    {psel, penable} <= 2'b00;
  endtask
  // compare the sampled pairs with a message built here
  task automatic chkmsg(input logic [1:0] t, input logic [3:0] arb,
    input logic [21:0] b, input int nb);
    logic [1:0] s, v;
    logic [2:0] u;
    s = 2'h0;
    chk("type", i_peer.rec[1], t);
    for (int i = 0; i < 4; i++) begin
      chk("arb", i_peer.rec[2 + i], {arb[3 - i], 1'b0});
    end
    for (int i = 0; i < nb; i++) begin
      v = b[2 * (nb - 1 - i) +: 2];
      chk("body", i_peer.rec[6 + i], v);
      u = s + v;
      s = (i == nb - 1) ? u[1:0] : u[1:0] + u[2]; // carry folds back
    end
    chk("sum", i_peer.rec[6 + nb], s);
    chk("zero", i_peer.rec[7 + nb], 32'h0);
  endtask
  // launch, wait for done, check status and frame, clear status
  task automatic send(input logic [7:0] a, input logic [31:0] d,
    input logic [1:0] t, input logic [3:0] arb, input logic [21:0] b,
    input int nb, input logic [31:0] st);
    m0 = i_peer.n_msg;
    apb(1'b1, a, d);
    if (st[2]) begin
      apb(1'b1, 8'h08, 32'h0); // refused while busy
      chk("busy", e, 1'b1);
    end
    do apb(1'b0, 8'h0C, 32'h0); while (r[1] !== 1'b1);
    chk("stat", r, st);
    chk("msgs", i_peer.n_msg - m0, st[2] ? 2 : 1);
    chkmsg(t, arb, b, nb);
    apb(1'b1, 8'h0C, st);
  endtask
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge ref_clk);
    bad_count++;
    report_and_stop;
  end
  initial begin
    repeat (10) @(posedge ref_clk);
    reset <= 1'b0;
    foreach (rows[k]) begin
      apb(1'b0, rows[k][40:33], 32'h0);
      chk("rd", r, rows[k][32:1]);
      chk("err", e, rows[k][0]);
    end
    apb(1'b1, 8'h00, 32'h00020045); // enable, physical id 4, arb id 5
    apb(1'b0, 8'h00, 32'h0);
    chk("ctrl", r, 32'h00020045);
    send(8'h04, 32'hA5, 2'h3, 4'h5, 22'hA5, 4, 32'h2);
    bad_at = i_peer.n_msg + 1;
    send(8'h04, 32'h5A, 2'h3, 4'h5, 22'h5A, 4, 32'h6);
    send(8'h08, 32'h0010053C, 2'h1, 4'h5, {6'h02, 8'h3C, 8'h05}, 11,
      32'h2);
    send(8'h08, 32'h00800011, 2'h1, 4'hF, {6'h00, 8'h11, 8'h0F}, 11,
      32'h2);
    report_and_stop;
  end
endmodule
